// [dv/hcr_phy_model.sv]
`timescale 1ns/1ps
`default_nettype none
module hcr_phy_model (
  input wire logic int_mdc_in,
  input wire logic ext_mdc_in,
  input wire logic ext_oe_in,
  input wire logic ext_o_in,
  input wire logic pull_in,
  output logic int_mdio_out,
  output logic ext_mdio_out
);
  logic int_bit = 1'b0;
  logic ext_bit = 1'b0;
  // answers flip on every rising mdc edge so a stale level never passes for data
  always @(posedge int_mdc_in) int_bit <= ~int_bit;
  always @(posedge ext_mdc_in) ext_bit <= ~ext_bit;
  assign int_mdio_out = int_bit;
  // a released line rests at the pull level, which is the strap; the phy answers while mdc is high
  assign ext_mdio_out = ext_oe_in ? ext_o_in : (ext_mdc_in ? ext_bit : pull_in);
endmodule
`default_nettype wire

// [dv/hcr_props.sv]
`timescale 1ns/1ps
`default_nettype none
module hcr_props (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic soft_reset_out,
  input wire logic clear_errors_out,
  input wire logic [15:0] rx_data_level_in,
  input wire logic [15:0] tx_data_bytes_out,
  input wire logic [15:0] tx_status_bytes_out,
  input wire logic [15:0] rx_data_bytes_out,
  input wire logic [15:0] rx_status_bytes_out,
  input wire logic rx_data_full_out,
  input wire logic mgmt_mdc_in,
  input wire logic int_mdc_out,
  input wire logic int_mdio_o_out,
  input wire logic ext_mdc_out,
  input wire logic ext_mdio_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_pulse;
    soft_reset_out [*4] ##1 !soft_reset_out;
  endsequence
  property p_route; (int_mdc_out | ext_mdc_out) == mgmt_mdc_in; endproperty
  property p_int_quiet; ext_mdc_out |-> !int_mdc_out && !int_mdio_o_out; endproperty
  property p_ext_quiet; int_mdc_out |-> !ext_mdc_out && !ext_mdio_oe_out; endproperty
  property p_pulse; $rose(soft_reset_out) |-> s_pulse; endproperty
  property p_clr; clear_errors_out == soft_reset_out; endproperty
  property p_rd_zero;
    !($past(rd_in) && $past(addr_in) == 8'h74) |-> rdata_out == 32'h0;
  endproperty
  property p_sum;
    tx_data_bytes_out + tx_status_bytes_out + rx_data_bytes_out + rx_status_bytes_out == 16'h4000;
  endproperty
  property p_full;
    $stable(rx_data_bytes_out) |-> rx_data_full_out ==
      (({4'h0, $past(rx_data_level_in)} + 20'h4) * 20'h4 >= {4'h0, rx_data_bytes_out});
  endproperty
  a_route: assert property (p_route) else $error("mdc not routed");
  a_int_quiet: assert property (p_int_quiet) else $error("internal mdc active");
  a_ext_quiet: assert property (p_ext_quiet) else $error("external side active");
  a_pulse: assert property (p_pulse) else $error("reset pulse length wrong");
  a_clr: assert property (p_clr) else $error("error clear mistimed");
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
  a_sum: assert property (p_sum) else $error("allocation not total");
  a_full: assert property (p_full) else $error("full flag wrong");
endmodule
bind hcr_hw_config hcr_props i_props (.clk_in, .rst_n_in, .addr_in, .rd_in, .rdata_out,
  .soft_reset_out, .clear_errors_out, .rx_data_level_in, .tx_data_bytes_out,
  .tx_status_bytes_out, .rx_data_bytes_out, .rx_status_bytes_out, .rx_data_full_out,
  .mgmt_mdc_in, .int_mdc_out, .int_mdio_o_out, .ext_mdc_out, .ext_mdio_oe_out);
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, on = 1'b1, pse = 1'b0;
  logic mdc = 1'b0, moe = 1'b0, mo = 1'b0, pull = 1'b1, mi, soft_reset_request, full, en_o;
  int strap = 1;
  logic imdc, imo, imoe, imi, emdc, emo, emoe, emi;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0, rdata_out;
  logic [15:0] lvl = 16'h0, txd, txs, rxd, rxs;
  int fail_count = 0, total_checks = 0, seed = 32'ha4e4, sel = 0, en = 0, sz = 5, to = 0, i, n;
  hcr_hw_config #(.TIMEOUT_CYC(20)) i_dut (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .phy_clks_running_in(on), .power_save_exit_in(pse),
    .rx_data_level_in(lvl), .soft_reset_out(soft_reset_request), .clear_errors_out(),
    .ext_mii_port_enable_out(en_o), .tx_data_bytes_out(txd), .tx_status_bytes_out(txs),
    .rx_data_bytes_out(rxd), .rx_status_bytes_out(rxs), .rx_data_full_out(full),
    .mgmt_mdc_in(mdc), .mgmt_mdio_o_in(mo), .mgmt_mdio_oe_in(moe), .mgmt_mdio_i_out(mi),
    .int_mdc_out(imdc), .int_mdio_o_out(imo), .int_mdio_oe_out(imoe), .int_mdio_i_in(imi),
    .ext_mdc_out(emdc), .ext_mdio_o_out(emo), .ext_mdio_oe_out(emoe), .ext_mdio_i_in(emi));
  hcr_phy_model i_phy (.int_mdc_in(imdc), .ext_mdc_in(emdc), .ext_oe_in(emoe),
    .ext_o_in(emo), .pull_in(pull), .int_mdio_out(imi), .ext_mdio_out(emi));
  initial forever #4 clk_in = ~clk_in;
  function automatic logic [31:0] ex();
    return {12'h0, sz[3:0], 11'h0, sel[0], strap[0], en[0], to[0], 1'b0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // strobes drop one edge before the next task may raise them again
  // no mac traffic runs in this bench, so every write meets the stopped-datapath rule
  task automatic wr(input logic [31:0] d);
    addr_in <= 8'h74;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    chk("rdata", rdata_out, exp);
    @(posedge clk_in);
  endtask
  task automatic wait_soft_reset_request(input logic v);
    for (n = 0; soft_reset_request !== v; n++) begin
      if (n == 100) begin
        chk("soft_reset_request wait", 0, 1);
        results();
      end
      @(posedge clk_in);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    wr(32'h0008_0014);
    rd(8'h74, ex());
    rd(8'h70, 32'h0);
    for (i = 2; i <= 14; i++) begin
      n = $random(seed);
      sel = (n >> 4) & 1;
      en = (n >> 2) & 1;
      sz = i;
      wr((i << 16) | (n & 32'hFFF0_FFFE));
      rd(8'h74, ex());
      chk("en", en_o, en);
      chk("txs", txs, 512);
      chk("txd", txd, i * 1024 - 512);
      chk("rxd", rxd, (16384 - i * 1024) * 15 / 16);
      chk("rxs", rxs, (16384 - i * 1024) / 16);
      mdc <= 1'b1;
      moe <= n[7];
      mo <= n[8];
      @(posedge clk_in);
      chk("mdio", mi, sel ? emi : imi);
      chk("mdc", {imdc, emdc}, sel ? 2'b01 : 2'b10);
      chk("oe", emoe, sel[0] & moe);
      chk("mdio pins", {imo, imoe, emo}, sel ? {2'b01, mo} : {mo, moe, 1'b0});
      mdc <= 1'b0;
      @(posedge clk_in);
    end
    $display("sizes and routing done");
    lvl <= 16'((16384 - sz * 1024) * 15 / 64 - 5);
    repeat (3) @(posedge clk_in);
    chk("full", full, 0);
    lvl <= 16'((16384 - sz * 1024) * 15 / 64 - 4);
    repeat (3) @(posedge clk_in);
    chk("full", full, 1);
    lvl <= 16'h0;
    pse <= 1'b1;
    @(posedge clk_in);
    pse <= 1'b0;
    wr(32'h0);
    rd(8'h74, ex());
    $display("full flag and write lock done");
    on <= 1'b0;
    wr(ex() | 32'h1);
    repeat (30) @(posedge clk_in);
    to = 1;
    chk("soft_reset_request", soft_reset_request, 0);
    rd(8'h74, ex());
    on <= 1'b1;
    wr(ex() | 32'h1);
    wait_soft_reset_request(1'b1);
    wait_soft_reset_request(1'b0);
    sel = 0;
    en = 0;
    sz = 5;
    to = 0;
    @(posedge clk_in);
    wr(32'h0003_0014);
    rd(8'h74, ex());
    chk("en", en_o, 0);
    $display("soft reset done");
    pull <= 1'b0;
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    strap = 0;
    @(posedge clk_in);
    rd(8'h74, ex());
    $display("hard reset strap done");
    results();
  end
endmodule
`default_nettype wire

// [include/hcr_alloc_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface hcr_alloc_if;
  logic [3:0] tx_alloc_size;
  logic [15:0] rx_data_level;
  logic [15:0] tx_data_bytes;
  logic [15:0] tx_status_bytes;
  logic [15:0] rx_data_bytes;
  logic [15:0] rx_status_bytes;
  logic rx_data_full;
  modport ctrl (output tx_alloc_size, output rx_data_level, input tx_data_bytes,
    input tx_status_bytes, input rx_data_bytes, input rx_status_bytes, input rx_data_full);
  modport calc (input tx_alloc_size, input rx_data_level, output tx_data_bytes,
    output tx_status_bytes, output rx_data_bytes, output rx_status_bytes, output rx_data_full);
endinterface
`default_nettype wire

// [include/hcr_pkg.sv]
package hcr_pkg;
  localparam logic [7:0] HARDWARE_CONFIGURATION_OFFSET = 8'h74;
  localparam int MGMT_SEL_BIT = 4;
  localparam int STRAP_BIT = 3;
  localparam int EXT_MII_EN_BIT = 2;
  localparam int SOFT_RESET_TIMEOUT_BIT = 1;
  localparam int SOFT_RESET_REQUEST_BIT = 0;
  localparam int TX_SIZE_LSB = 16;
  localparam int TX_SIZE_W = 4;
  localparam logic [3:0] TX_SIZE_RESET = 4'h5;
  localparam logic [15:0] TOTAL_BYTES = 16'h4000;
  localparam logic [15:0] KB_BYTES = 16'h0400;
  localparam logic [15:0] TX_STATUS_BYTES = 16'h0200;
  localparam logic [15:0] RX_FULL_MARGIN_WORDS = 16'h0004;
  localparam int SOFT_RESET_REQUEST_TIMEOUT_NS = 10000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SOFT_RESET_REQUEST_TIMEOUT_CYC = SOFT_RESET_REQUEST_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int SOFT_RESET_REQUEST_PULSE_CYC = 4;
  typedef enum logic [1:0] {HCR_IDLE, HCR_WAIT_CLK, HCR_PULSE} hcr_soft_reset_request_state_t;
endpackage

// [verilog/hcr_fifo_alloc.sv]
`timescale 1ns/1ps
`default_nettype none
module hcr_fifo_alloc (
  input wire logic clk_in,
  input wire logic rst_n_in,
  hcr_alloc_if.calc alloc
);
  logic [15:0] nxt_tx_data, nxt_rx_data, nxt_rx_stat, rx_total, tx_total;
  logic [15:0] tx_data_ff, rx_data_ff, rx_stat_ff;
  logic nxt_full, full_ff;
  // reset split follows the size field's reset so the four parts add up from the start
  localparam logic [15:0] TX_TOTAL_RST = 16'({hcr_pkg::TX_SIZE_RESET, 10'h000});
  localparam logic [15:0] RX_TOTAL_RST = hcr_pkg::TOTAL_BYTES - TX_TOTAL_RST;
  localparam logic [15:0] RX_STAT_RST = RX_TOTAL_RST >> 4;
  localparam logic [15:0] TX_DATA_RST = TX_TOTAL_RST - hcr_pkg::TX_STATUS_BYTES;
  localparam logic [15:0] RX_DATA_RST = RX_TOTAL_RST - RX_STAT_RST;

  always_comb begin
    tx_total = 16'({alloc.tx_alloc_size, 10'h000});
    nxt_tx_data = tx_total - hcr_pkg::TX_STATUS_BYTES;
    rx_total = hcr_pkg::TOTAL_BYTES - tx_total;
    nxt_rx_stat = {4'h0, rx_total[15:4]};
    nxt_rx_data = rx_total - nxt_rx_stat;
    // level in words; full four words short of the data fifo length
    nxt_full = ({alloc.rx_data_level, 2'h0} + 18'({hcr_pkg::RX_FULL_MARGIN_WORDS, 2'h0}))
               >= {2'h0, nxt_rx_data};
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_data_ff <= TX_DATA_RST;
      rx_data_ff <= RX_DATA_RST;
      rx_stat_ff <= RX_STAT_RST;
      full_ff <= 1'b0;
    end else begin
      tx_data_ff <= nxt_tx_data;
      rx_data_ff <= nxt_rx_data;
      rx_stat_ff <= nxt_rx_stat;
      full_ff <= nxt_full;
    end
  end

  assign alloc.tx_data_bytes = tx_data_ff;
  assign alloc.tx_status_bytes = hcr_pkg::TX_STATUS_BYTES;
  assign alloc.rx_data_bytes = rx_data_ff;
  assign alloc.rx_status_bytes = rx_stat_ff;
  assign alloc.rx_data_full = full_ff;
endmodule
`default_nettype wire

// [verilog/hcr_hw_config.sv]
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module hcr_hw_config #(
  parameter int TIMEOUT_CYC = hcr_pkg::SOFT_RESET_REQUEST_TIMEOUT_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic phy_clks_running_in,
  input wire logic power_save_exit_in,
  input wire logic [15:0] rx_data_level_in,
  output logic soft_reset_out,
  output logic clear_errors_out,
  output logic ext_mii_port_enable_out,
  output logic [15:0] tx_data_bytes_out,
  output logic [15:0] tx_status_bytes_out,
  output logic [15:0] rx_data_bytes_out,
  output logic [15:0] rx_status_bytes_out,
  output logic rx_data_full_out,
  input wire logic mgmt_mdc_in,
  input wire logic mgmt_mdio_o_in,
  input wire logic mgmt_mdio_oe_in,
  output logic mgmt_mdio_i_out,
  output logic int_mdc_out,
  output logic int_mdio_o_out,
  output logic int_mdio_oe_out,
  input wire logic int_mdio_i_in,
  output logic ext_mdc_out,
  output logic ext_mdio_o_out,
  output logic ext_mdio_oe_out,
  input wire logic ext_mdio_i_in
);
  localparam int CW = $clog2(TIMEOUT_CYC + 1);

  hcr_alloc_if alloc ();

  logic mgmt_port_select_ff, nxt_mgmt_port_select;
  logic ext_mii_port_enable_ff, nxt_ext_mii_port_enable;
  logic soft_reset_timeout_ff, nxt_soft_reset_timeout;
  logic soft_reset_request_ff, nxt_soft_reset_request;
  logic [3:0] tx_alloc_size_ff, nxt_tx_alloc_size;
  logic read_seen_ff, nxt_read_seen;
  logic strap_taken_ff, nxt_strap_taken;
  logic ext_phy_present_strap_ff, nxt_ext_phy_present_strap;
  logic [31:0] rdata_ff, nxt_rdata;
  hcr_pkg::hcr_soft_reset_request_state_t state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic hit, wr_ok, pulse_end;

  // true in the last cycle of a span counted from zero
  function automatic logic cnt_at_last(input logic [CW-1:0] cnt, input int span);
    return cnt == CW'(span - 1);
  endfunction

  assign hit = (addr_in == hcr_pkg::HARDWARE_CONFIGURATION_OFFSET);
  assign wr_ok = wr_in && hit && read_seen_ff;
  assign pulse_end = (state_ff == hcr_pkg::HCR_PULSE)
                     && cnt_at_last(cnt_ff, hcr_pkg::SOFT_RESET_REQUEST_PULSE_CYC);

  // strap caught on the first clock after hard reset release; soft reset leaves it
  always_comb begin
    nxt_strap_taken = 1'b1;
    nxt_ext_phy_present_strap = ext_phy_present_strap_ff;
    if (!strap_taken_ff) begin
      nxt_ext_phy_present_strap = ext_mdio_i_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_taken_ff <= 1'b0;
      ext_phy_present_strap_ff <= 1'b0;
    end else begin
      strap_taken_ff <= nxt_strap_taken;
      ext_phy_present_strap_ff <= nxt_ext_phy_present_strap;
    end
  end

  // lock re-armed by power-save exit and by the end of a soft reset
  always_comb begin
    nxt_read_seen = read_seen_ff;
    if (rd_in && hit) begin
      nxt_read_seen = 1'b1;
    end
    if (power_save_exit_in || pulse_end) begin
      nxt_read_seen = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      read_seen_ff <= 1'b0;
    end else begin
      read_seen_ff <= nxt_read_seen;
    end
  end

  // zero outside the answer slot so a stale word never lingers on the bus
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (rd_in && hit) begin
      nxt_rdata[hcr_pkg::TX_SIZE_LSB +: hcr_pkg::TX_SIZE_W] = tx_alloc_size_ff;
      nxt_rdata[hcr_pkg::MGMT_SEL_BIT] = mgmt_port_select_ff;
      nxt_rdata[hcr_pkg::STRAP_BIT] = ext_phy_present_strap_ff;
      nxt_rdata[hcr_pkg::EXT_MII_EN_BIT] = ext_mii_port_enable_ff;
      nxt_rdata[hcr_pkg::SOFT_RESET_TIMEOUT_BIT] = soft_reset_timeout_ff;
      nxt_rdata[hcr_pkg::SOFT_RESET_REQUEST_BIT] = soft_reset_request_ff;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // settings and the soft reset sequencer share one group: the pulse resets the settings

  always_comb begin
    nxt_mgmt_port_select = mgmt_port_select_ff;
    nxt_ext_mii_port_enable = ext_mii_port_enable_ff;
    nxt_tx_alloc_size = tx_alloc_size_ff;
    nxt_soft_reset_timeout = soft_reset_timeout_ff;
    nxt_soft_reset_request = soft_reset_request_ff;
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    if (wr_ok && state_ff == hcr_pkg::HCR_IDLE) begin
      nxt_mgmt_port_select = wdata_in[hcr_pkg::MGMT_SEL_BIT];
      nxt_ext_mii_port_enable = wdata_in[hcr_pkg::EXT_MII_EN_BIT];
      nxt_tx_alloc_size = wdata_in[hcr_pkg::TX_SIZE_LSB +: hcr_pkg::TX_SIZE_W];
      if (wdata_in[hcr_pkg::SOFT_RESET_REQUEST_BIT]) begin
        nxt_soft_reset_request = 1'b1;
        nxt_soft_reset_timeout = 1'b0;
        nxt_state = hcr_pkg::HCR_WAIT_CLK;
        nxt_cnt = '0;
      end
    end
    unique case (state_ff)
      hcr_pkg::HCR_IDLE: begin
      end
      hcr_pkg::HCR_WAIT_CLK: begin
        if (phy_clks_running_in) begin
          nxt_state = hcr_pkg::HCR_PULSE;
          nxt_cnt = '0;
        end else if (cnt_at_last(cnt_ff, TIMEOUT_CYC)) begin
          nxt_soft_reset_timeout = 1'b1;
          nxt_soft_reset_request = 1'b0;
          nxt_state = hcr_pkg::HCR_IDLE;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      hcr_pkg::HCR_PULSE: begin
        if (pulse_end) begin
          nxt_soft_reset_request = 1'b0;
          nxt_state = hcr_pkg::HCR_IDLE;
          // settings reset with the rest of the system registers
          nxt_mgmt_port_select = 1'b0;
          nxt_ext_mii_port_enable = 1'b0;
          nxt_tx_alloc_size = hcr_pkg::TX_SIZE_RESET;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      // the fourth code of the state register is unused
      default: begin
        nxt_state = hcr_pkg::HCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mgmt_port_select_ff <= 1'b0;
      ext_mii_port_enable_ff <= 1'b0;
      soft_reset_timeout_ff <= 1'b0;
      soft_reset_request_ff <= 1'b0;
      tx_alloc_size_ff <= hcr_pkg::TX_SIZE_RESET;
      state_ff <= hcr_pkg::HCR_IDLE;
      cnt_ff <= '0;
    end else begin
      mgmt_port_select_ff <= nxt_mgmt_port_select;
      ext_mii_port_enable_ff <= nxt_ext_mii_port_enable;
      soft_reset_timeout_ff <= nxt_soft_reset_timeout;
      soft_reset_request_ff <= nxt_soft_reset_request;
      tx_alloc_size_ff <= nxt_tx_alloc_size;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  assign rdata_out = rdata_ff;
  assign soft_reset_out = (state_ff == hcr_pkg::HCR_PULSE);
  assign clear_errors_out = (state_ff == hcr_pkg::HCR_PULSE);
  assign ext_mii_port_enable_out = ext_mii_port_enable_ff;

  // management steering; the unselected side is held quiet
  always_comb begin
    if (mgmt_port_select_ff) begin
      int_mdc_out = 1'b0;
      int_mdio_o_out = 1'b0;
      int_mdio_oe_out = 1'b1;
      ext_mdc_out = mgmt_mdc_in;
      ext_mdio_o_out = mgmt_mdio_o_in;
      ext_mdio_oe_out = mgmt_mdio_oe_in;
      mgmt_mdio_i_out = ext_mdio_i_in;
    end else begin
      int_mdc_out = mgmt_mdc_in;
      int_mdio_o_out = mgmt_mdio_o_in;
      int_mdio_oe_out = mgmt_mdio_oe_in;
      ext_mdc_out = 1'b0;
      ext_mdio_o_out = 1'b0;
      ext_mdio_oe_out = 1'b0;
      mgmt_mdio_i_out = int_mdio_i_in;
    end
  end

  assign alloc.tx_alloc_size = tx_alloc_size_ff;
  assign alloc.rx_data_level = rx_data_level_in;
  assign tx_data_bytes_out = alloc.tx_data_bytes;
  assign tx_status_bytes_out = alloc.tx_status_bytes;
  assign rx_data_bytes_out = alloc.rx_data_bytes;
  assign rx_status_bytes_out = alloc.rx_status_bytes;
  assign rx_data_full_out = alloc.rx_data_full;

  hcr_fifo_alloc u_alloc (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .alloc(alloc)
  );
endmodule
`default_nettype wire
